// >>> rtl/spr_ctl.sv
// Command decode, bursts, precharge, refresh and power control of the SDRAM device.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "spr_map.svh"
module spr_ctl
  import spr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeEnableN,
  input wire logic clockEnable,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic precharge_all_select_bit,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic regWriteStrobe,
  input wire logic regReadStrobe,
  output logic [31:0] regReadData,
  output logic [3:0] bankActive,
  output logic [3:0] prechargeStart,
  output logic [11:0] refreshRow,
  output logic refreshPulse,
  output logic refreshBusy,
  output logic selfRefreshActive,
  output logic powerDownActive,
  output logic activePowerDown,
  output logic clockSuspended,
  output logic inputBufferEnable,
  output logic burstActive,
  output logic readOutValid,
  output logic writeStore
);

  // ****************************************************************
  // State and decode
  // ****************************************************************
  spr_state_type st;
  spr_state_type next_st;
  logic [3:0] bankRecovering;
  logic [3:0] act;
  logic [3:0] pcNow;
  logic [3:0] pcWr;
  logic autoRefresh;
  logic intEdge;
  logic cmdNop;
  logic cmdActivate;
  logic cmdRead;
  logic cmdWrite;
  logic cmdPrecharge;
  logic cmdRefresh;
  logic cmdTerminate;
  logic [1:0] bank;
  logic [1:0] casLatency;
  logic [2:0] lengthCode;
  logic singleWrite;
  logic [3:0] newLength;
  logic newAuto;
  logic newCont;
  logic readIssue;
  logic lastElem;

  // Command pins are decoded as a group when chip select is low.
  assign cmdNop = chipSelectN || (rowStrobeN && columnStrobeN && writeEnableN);
  assign cmdActivate = !chipSelectN && !rowStrobeN && columnStrobeN && writeEnableN;
  assign cmdRead = !chipSelectN && rowStrobeN && !columnStrobeN && writeEnableN;
  assign cmdWrite = !chipSelectN && rowStrobeN && !columnStrobeN && !writeEnableN;
  assign cmdPrecharge = !chipSelectN && !rowStrobeN && columnStrobeN && !writeEnableN;
  assign cmdRefresh = !chipSelectN && !rowStrobeN && !columnStrobeN && writeEnableN;
  assign cmdTerminate = !chipSelectN && rowStrobeN && columnStrobeN && !writeEnableN;
  assign bank = {bank_select_high, bank_select_low};
  assign casLatency = st.cfg[`SPR_CFG_CL_MSB:`SPR_CFG_CL_LSB];
  assign lengthCode = st.cfg[`SPR_CFG_BL_MSB:`SPR_CFG_BL_LSB];
  assign singleWrite = st.cfg[`SPR_CFG_SINGLE_WRITE];

  // An internal edge exists only when clock enable was high at the last edge.
  assign intEdge = st.ckePrev && (st.power == PWR_NORMAL);

  // ****************************************************************
  // Burst set-up for a new access
  // ****************************************************************
  // Length and auto precharge of a new access, decided for that access alone.
  always_comb begin
    newCont = (lengthCode == `SPR_BL_CONTINUOUS);
    if (cmdWrite && singleWrite && !newCont) begin
      newLength = 4'h1;
    end else begin
      unique case (lengthCode[1:0])
        2'h0: newLength = 4'h1;
        2'h1: newLength = 4'h2;
        2'h2: newLength = 4'h4;
        2'h3: newLength = 4'h8;
      endcase
    end
    newAuto = precharge_all_select_bit && !newCont;
  end

  // ****************************************************************
  // Main next-state logic
  // ****************************************************************
  // Commands, burst progress, precharge requests and power state.
  always_comb begin
    next_st = st;
    act = 4'h0;
    pcNow = 4'h0;
    pcWr = 4'h0;
    autoRefresh = 1'b0;
    readIssue = 1'b0;
    lastElem = 1'b0;
    next_st.ckePrev = clockEnable;
    next_st.writeStore = 1'b0;
    next_st.refreshBusy = (st.refreshCount > 4'h1);
    if (st.refreshCount != 4'h0) begin
      next_st.refreshCount = st.refreshCount - 4'h1;
    end
    unique case (st.power)
      PWR_NORMAL: begin
        if (intEdge) begin
          // Burst progress for the running access.
          if (st.burstActive) begin
            readIssue = !st.burstWrite;
            next_st.writeStore = st.burstWrite;
            lastElem = !st.burstCont && (st.burstLeft == 4'h1);
            if (!st.burstCont) begin
              next_st.burstLeft = st.burstLeft - 4'h1;
            end
            if (lastElem) begin
              next_st.burstActive = 1'b0;
              if (st.burstAuto && st.burstWrite) begin
                pcWr[st.burstBank] = 1'b1;
              end else if (st.burstAuto) begin
                pcNow[st.burstBank] = 1'b1;
              end
            end
          end
          if (cmdActivate) begin
            act[bank] = 1'b1;
          end
          if (cmdPrecharge) begin
            if (precharge_all_select_bit) begin
              pcNow = 4'hF;
            end else begin
              pcNow[bank] = 1'b1;
            end
            if (st.burstActive && (precharge_all_select_bit || bank == st.burstBank)) begin
              next_st.burstActive = 1'b0;
            end
          end
          if (cmdTerminate && st.burstActive) begin
            next_st.burstActive = 1'b0;
          end
          if (cmdRead || cmdWrite) begin
            // A new access cuts short whatever burst is running.
            readIssue = cmdRead;
            next_st.writeStore = cmdWrite;
            if (st.burstActive && !lastElem && st.burstAuto && st.burstBank != bank) begin
              if (st.burstWrite) begin
                pcWr[st.burstBank] = 1'b1;
              end else begin
                pcNow[st.burstBank] = 1'b1;
              end
            end
            next_st.burstActive = (newLength != 4'h1) || newCont;
            next_st.burstWrite = cmdWrite;
            next_st.burstAuto = newAuto;
            next_st.burstCont = newCont;
            next_st.burstBank = bank;
            next_st.burstLeft = newLength - 4'h1;
            if (newLength == 4'h1 && newAuto) begin
              if (cmdWrite) begin
                pcWr[bank] = 1'b1;
              end else begin
                pcNow[bank] = 1'b1;
              end
            end
          end
          if (cmdRefresh && clockEnable) begin
            autoRefresh = 1'b1;
            next_st.refreshCount = 4'(`SPR_RFC_CYC);
            next_st.refreshBusy = 1'b1;
          end else if (cmdRefresh) begin
            next_st.power = PWR_SELF;
            next_st.selfRefreshActive = 1'b1;
            next_st.inputBufferEnable = 1'b0;
          end else if (!clockEnable && cmdNop && !st.burstActive &&
                       st.refreshCount == 4'h0 && bankRecovering == 4'h0) begin
            next_st.power = PWR_DOWN;
            next_st.powerDownActive = 1'b1;
            next_st.activePowerDown = (bankActive != 4'h0);
            next_st.inputBufferEnable = 1'b0;
          end
        end
        next_st.clockSuspended = !clockEnable && next_st.burstActive;
      end
      PWR_DOWN: begin
        // Clock enable and the command are watched; a high value with an idle command wakes it.
        if (clockEnable && cmdNop) begin
          next_st.power = PWR_NORMAL;
          next_st.powerDownActive = 1'b0;
          next_st.activePowerDown = 1'b0;
          next_st.inputBufferEnable = 1'b1;
        end
      end
      PWR_SELF: begin
        // Every input but clock enable is ignored here.
        if (clockEnable) begin
          next_st.power = PWR_NORMAL;
          next_st.selfRefreshActive = 1'b0;
          next_st.inputBufferEnable = 1'b1;
        end
      end
    endcase
    // Read data leave the device a CAS latency after each element.
    if (intEdge) begin
      next_st.readPipe = {st.readPipe[2:0], readIssue};
      if (cmdWrite && st.burstActive && !st.burstWrite) begin
        next_st.readPipe = 4'h0;
      end
    end
    unique case (casLatency)
      2'h0: next_st.readOutValid = next_st.readPipe[0];
      2'h1: next_st.readOutValid = next_st.readPipe[0];
      2'h2: next_st.readOutValid = next_st.readPipe[1];
      2'h3: next_st.readOutValid = next_st.readPipe[2];
    endcase
    // Register port: a write updates the configuration, a read answers next cycle.
    if (regWriteStrobe && regAddr == `SPR_REG_CONFIG) begin
      next_st.cfg = regWriteData[7:0];
    end
    next_st.regReadData = 32'h0000_0000;
    if (regReadStrobe) begin
      unique case (regAddr)
        `SPR_REG_CONFIG: next_st.regReadData = {24'h00_0000, st.cfg};
        `SPR_REG_STATUS: next_st.regReadData = {22'h00_0000, st.refreshBusy,
                                               st.clockSuspended, st.burstActive,
                                               st.activePowerDown, st.powerDownActive,
                                               st.selfRefreshActive, bankActive};
        `SPR_REG_ROW: next_st.regReadData = {20'h0_0000, refreshRow};
        default: next_st.regReadData = 32'h0000_0000;
      endcase
    end
  end

  // Registers the whole control state.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
      st.power <= PWR_NORMAL;
      st.cfg <= `SPR_CONFIG_RESET;
      st.inputBufferEnable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // Banks and refresh counter
  // ****************************************************************
  // One tracker per bank.
  genvar gi;
  generate
    for (gi = 0; gi < `SPR_BANKS; gi++) begin : gBank
      spr_bank_state uBank (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .activate(act[gi]),
        .prechargeNow(pcNow[gi]),
        .prechargeAfterWr(pcWr[gi]),
        .bankActive(bankActive[gi]),
        .bankRecovering(bankRecovering[gi]),
        .prechargeStart(prechargeStart[gi])
      );
    end
  endgenerate

  // Row counter shared by auto refresh and self refresh.
  spr_refresh_ctr uRefresh (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .autoRefresh(autoRefresh),
    .selfActive(st.selfRefreshActive),
    .refreshRow(refreshRow),
    .refreshPulse(refreshPulse)
  );

  assign regReadData = st.regReadData;
  assign refreshBusy = st.refreshBusy;
  assign selfRefreshActive = st.selfRefreshActive;
  assign powerDownActive = st.powerDownActive;
  assign activePowerDown = st.activePowerDown;
  assign clockSuspended = st.clockSuspended;
  assign inputBufferEnable = st.inputBufferEnable;
  assign burstActive = st.burstActive;
  assign readOutValid = st.readOutValid;
  assign writeStore = st.writeStore;

endmodule : spr_ctl

// >>> rtl/spr_map.svh
// Constants for the bank, precharge, refresh and power control of the SDRAM device.
`ifndef SPR_MAP_SVH
`define SPR_MAP_SVH

// ****************************************************************
// Register offsets and fields
// ****************************************************************
`define SPR_REG_CONFIG 4'h0
`define SPR_REG_STATUS 4'h4
`define SPR_REG_ROW 4'h8
`define SPR_CONFIG_RESET 8'h0A
`define SPR_CFG_CL_LSB 0
`define SPR_CFG_CL_MSB 1
`define SPR_CFG_BL_LSB 2
`define SPR_CFG_BL_MSB 4
`define SPR_CFG_SINGLE_WRITE 5
`define SPR_BL_CONTINUOUS 3'h7
`define SPR_ROW_WIDTH 12
`define SPR_BANKS 4

// ****************************************************************
// Timing
// ****************************************************************
`define SPR_CLK_PERIOD_NS 10
`define SPR_ROW_PRECHARGE_TIME_NS 20
`define SPR_WRITE_RECOVERY_TIME_NS 15
`define SPR_REFRESH_CYCLE_TIME_NS 66
`define SPR_SELF_REFRESH_INTERVAL_NS 7800
`define SPR_RP_CYC ((`SPR_ROW_PRECHARGE_TIME_NS + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS)
`define SPR_WR_CYC ((`SPR_WRITE_RECOVERY_TIME_NS + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS)
`define SPR_RFC_CYC ((`SPR_REFRESH_CYCLE_TIME_NS + `SPR_CLK_PERIOD_NS - 1) / `SPR_CLK_PERIOD_NS)
`define SPR_SR_INTERVAL_CYC (`SPR_SELF_REFRESH_INTERVAL_NS / `SPR_CLK_PERIOD_NS)

`endif

// >>> rtl/spr_pkg.sv
// Types shared by the SDRAM bank, refresh and power control modules.
package spr_pkg;

  // Power states of the device.
  typedef enum logic [1:0] {
    PWR_NORMAL,
    PWR_DOWN,
    PWR_SELF
  } spr_power_type;

  // State of the main control module.
  typedef struct packed {
    spr_power_type power;
    logic ckePrev;
    logic [7:0] cfg;
    logic burstActive;
    logic burstWrite;
    logic burstAuto;
    logic burstCont;
    logic [1:0] burstBank;
    logic [3:0] burstLeft;
    logic [3:0] readPipe;
    logic readOutValid;
    logic writeStore;
    logic clockSuspended;
    logic selfRefreshActive;
    logic powerDownActive;
    logic activePowerDown;
    logic inputBufferEnable;
    logic refreshBusy;
    logic [3:0] refreshCount;
    logic [31:0] regReadData;
  } spr_state_type;

  // State of one bank.
  typedef struct packed {
    logic active;
    logic prechargeStart;
    logic [3:0] wrCount;
    logic [3:0] rpCount;
  } spr_bank_type;

  // State of the refresh row counter and the self refresh oscillator.
  typedef struct packed {
    logic [11:0] row;
    logic [15:0] osc;
    logic pulse;
  } spr_refresh_type;

endpackage : spr_pkg

// >>> rtl/spr_bank_state.sv
// One bank: open row flag, delayed auto precharge and precharge recovery.
`timescale 1ns/1ps
`include "spr_map.svh"
module spr_bank_state
  import spr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic activate,
  input wire logic prechargeNow,
  input wire logic prechargeAfterWr,
  output logic bankActive,
  output logic bankRecovering,
  output logic prechargeStart
);

  spr_bank_type st;
  spr_bank_type next_st;
  logic fire;

  // Counts write recovery down, then closes the row and starts recovery.
  always_comb begin
    next_st = st;
    next_st.prechargeStart = 1'b0;
    fire = prechargeNow;
    if (st.rpCount != 4'h0) begin
      next_st.rpCount = st.rpCount - 4'h1;
    end
    if (st.wrCount != 4'h0) begin
      next_st.wrCount = st.wrCount - 4'h1;
      if (st.wrCount == 4'h1) begin
        fire = 1'b1;
      end
    end
    if (prechargeAfterWr) begin
      next_st.wrCount = 4'(`SPR_WR_CYC);
    end
    if (fire && st.active) begin
      next_st.active = 1'b0;
      next_st.prechargeStart = 1'b1;
      next_st.rpCount = 4'(`SPR_RP_CYC);
      next_st.wrCount = 4'h0;
    end
    if (activate) begin
      next_st.active = 1'b1;
    end
  end

  // Registers the bank state.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign bankActive = st.active;
  assign bankRecovering = (st.rpCount != 4'h0);
  assign prechargeStart = st.prechargeStart;

endmodule : spr_bank_state

// >>> rtl/spr_refresh_ctr.sv
// Shared refresh row counter and the self refresh internal oscillator.
`timescale 1ns/1ps
`include "spr_map.svh"
module spr_refresh_ctr
  import spr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic autoRefresh,
  input wire logic selfActive,
  output logic [11:0] refreshRow,
  output logic refreshPulse
);

  spr_refresh_type st;
  spr_refresh_type next_st;
  logic doRefresh;

  // The oscillator only runs in self refresh; both sources step the row.
  always_comb begin
    next_st = st;
    doRefresh = autoRefresh;
    if (selfActive) begin
      if (st.osc == 16'h0000) begin
        doRefresh = 1'b1;
        next_st.osc = 16'(`SPR_SR_INTERVAL_CYC - 1);
      end else begin
        next_st.osc = st.osc - 16'h0001;
      end
    end else begin
      next_st.osc = 16'(`SPR_SR_INTERVAL_CYC - 1);
    end
    next_st.pulse = doRefresh;
    if (doRefresh) begin
      next_st.row = st.row + 12'h001;
    end
  end

  // Registers the counter state.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign refreshRow = st.row;
  assign refreshPulse = st.pulse;

endmodule : spr_refresh_ctr

// >>> sim/spr_mc_model.sv
// Memory controller model that issues commands to the device.
`timescale 1ns/1ps
module spr_mc_model (
  input wire logic sys_clk,
  output logic chipSelectN,
  output logic rowStrobeN,
  output logic columnStrobeN,
  output logic writeEnableN,
  output logic clockEnable,
  output logic bank_select_low,
  output logic bank_select_high,
  output logic precharge_all_select_bit
);
  // Pins start idle with the clock enable high.
  initial begin
    {chipSelectN, rowStrobeN, columnStrobeN, writeEnableN} = 4'h7;
    {clockEnable, bank_select_high, bank_select_low, precharge_all_select_bit} = 4'h8;
  end
  // Puts one command on the pins; it is taken at the next rising edge.
  task automatic cmd(input logic [3:0] k, input logic [1:0] b, input logic ap,
                     input logic ce);
    {chipSelectN, rowStrobeN, columnStrobeN, writeEnableN} <= k;
    {bank_select_high, bank_select_low, precharge_all_select_bit} <= {b, ap};
    clockEnable <= ce;
    @(posedge sys_clk);
  endtask : cmd
  // Idles for n edges; released address pins flip so no stale value lingers.
  task automatic nop(input int n, input logic ce);
    {chipSelectN, rowStrobeN, columnStrobeN, writeEnableN} <= 4'h7;
    {bank_select_high, bank_select_low} <= ~{bank_select_high, bank_select_low};
    precharge_all_select_bit <= ~precharge_all_select_bit;
    clockEnable <= ce;
    repeat (n) @(posedge sys_clk);
  endtask : nop
endmodule : spr_mc_model

// >>> sim/spr_ctl_chk.sv
// Assertions on the bank, refresh and power outputs of the device control.
`timescale 1ns/1ps
module spr_ctl_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic chipSelectN,
  input wire logic rowStrobeN,
  input wire logic columnStrobeN,
  input wire logic writeEnableN,
  input wire logic clockEnable,
  input wire logic bank_select_low,
  input wire logic bank_select_high,
  input wire logic precharge_all_select_bit,
  input wire logic [3:0] bankActive,
  input wire logic refreshPulse,
  input wire logic refreshBusy,
  input wire logic selfRefreshActive,
  input wire logic powerDownActive,
  input wire logic activePowerDown,
  input wire logic clockSuspended,
  input wire logic inputBufferEnable,
  input wire logic burstActive
);
  logic ckeQ;
  logic [3:0] cmd;
  logic [1:0] bank;
  logic go;
  // Keeps the clock enable of the previous edge, as the device does.
  always_ff @(posedge sys_clk) begin
    ckeQ <= sys_rst ? 1'b0 : clockEnable;
  end
  // A command counts only while the device is awake and not suspended.
  assign cmd = {chipSelectN, rowStrobeN, columnStrobeN, writeEnableN};
  assign bank = {bank_select_high, bank_select_low};
  assign go = ckeQ && !powerDownActive && !selfRefreshActive && !clockSuspended;
  default clocking dcb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  pre_one_a: assert property (go && clockEnable && cmd == 4'h2 && !precharge_all_select_bit
    |=> !bankActive[$past(bank)]) else $error("precharged bank still open");
  pre_all_a: assert property (go && clockEnable && cmd == 4'h2 && precharge_all_select_bit
    |=> bankActive == 4'h0) else $error("precharge all left a bank open");
  act_open_a: assert property (go && clockEnable && cmd == 4'h3
    |=> bankActive[$past(bank)]) else $error("activated bank not open");
  ref_start_a: assert property (go && clockEnable && cmd == 4'h1
    |=> refreshPulse && refreshBusy) else $error("refresh did not start");
  self_entry_a: assert property (go && !clockEnable && cmd == 4'h1
    |=> selfRefreshActive) else $error("self refresh not entered");
  self_hold_a: assert property (selfRefreshActive && !clockEnable
    |=> selfRefreshActive && $stable(bankActive)) else $error("self refresh disturbed");
  pd_kind_a: assert property (powerDownActive
    |-> activePowerDown == (|bankActive) && !inputBufferEnable) else $error("bad power-down kind");
  pd_cause_a: assert property ($rose(powerDownActive)
    |-> !$past(clockEnable) && ($past(chipSelectN) || $past(cmd) == 4'h7)
    && !$past(burstActive)) else $error("power-down without cause");
  suspend_cause_a: assert property ($rose(clockSuspended)
    |-> !$past(clockEnable) && $past(burstActive)) else $error("suspend without burst");
  // Main scenarios that must be reached.
  cover property ($rose(selfRefreshActive));
  cover property ($rose(activePowerDown));
  cover property ($rose(clockSuspended));
endmodule : spr_ctl_chk
bind spr_ctl spr_ctl_chk i_chk (.sys_clk, .sys_rst, .chipSelectN, .rowStrobeN, .columnStrobeN,
  .writeEnableN, .clockEnable, .bank_select_low, .bank_select_high, .precharge_all_select_bit,
  .bankActive, .refreshPulse, .refreshBusy, .selfRefreshActive, .powerDownActive,
  .activePowerDown, .clockSuspended, .inputBufferEnable, .burstActive);

// >>> sim/spr_ctl_tb_top.sv
// Self-checking bench for the bank, refresh and power control of the device.
`timescale 1ns/1ps
module spr_ctl_tb_top;
  localparam logic [3:0] CmdAct = 4'h3, CmdRd = 4'h5, CmdWr = 4'h4, CmdPre = 4'h2;
  localparam logic [3:0] CmdRef = 4'h1, CmdTerm = 4'h6;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic chipSelectN, rowStrobeN, columnStrobeN, writeEnableN, clockEnable;
  logic bank_select_low, bank_select_high, precharge_all_select_bit;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWriteData = 32'h0;
  logic regWriteStrobe = 1'b0;
  logic regReadStrobe = 1'b0;
  logic [31:0] regReadData;
  logic [3:0] bankActive, prechargeStart;
  logic [11:0] refreshRow;
  logic refreshPulse, refreshBusy, selfRefreshActive, powerDownActive, activePowerDown;
  logic clockSuspended, inputBufferEnable, burstActive, readOutValid, writeStore;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  spr_ctl i_dut (.*);
  spr_mc_model i_mc (.*);
  // Clock of 10 ns; a hung run is cut short by the cycle ceiling.
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      end_sim();
    end
  end
  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Compares the open-bank flags.
  task automatic cb(input logic [3:0] e);
    chk(32'(bankActive), 32'(e));
  endtask : cb
  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("Checks %0d, errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Register bus write and read; read data is taken the cycle after the strobe.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWriteData <= d;
    regWriteStrobe <= 1'b1;
    @(posedge sys_clk);
    regWriteStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    regAddr <= a;
    regReadStrobe <= 1'b1;
    @(posedge sys_clk);
    regReadStrobe <= 1'b0;
    @(posedge sys_clk);
    chk(regReadData, e);
  endtask : rd
  // Short forms of the controller model's command and idle tasks.
  task automatic c(input logic [3:0] k, input logic [1:0] b, input logic ap = 1'b0,
                   input logic ce = 1'b1);
    i_mc.cmd(k, b, ap, ce);
  endtask : c
  task automatic n(input int k, input logic ce = 1'b1);
    i_mc.nop(k, ce);
  endtask : n
  // Single-bank and all-bank precharge.
  task automatic t_pre();
    c(CmdAct, 2'h0);
    c(CmdAct, 2'h1);
    n(1);
    cb(4'h3);
    c(CmdPre, 2'h0);
    n(1);
    cb(4'h2);
    chk(32'(prechargeStart), 32'h1);
    c(CmdPre, 2'h0, 1'b1);
    n(1);
    cb(4'h0);
    chk(32'(prechargeStart), 32'h2);
    n(2);
  endtask : t_pre
  // Read with auto precharge closes the bank; a plain read leaves it open.
  task automatic t_auto();
    c(CmdAct, 2'h1);
    n(2);
    c(CmdRd, 2'h1, 1'b1);
    n(3);
    cb(4'h2);
    n(2);
    cb(4'h0);
    n(2);
    c(CmdAct, 2'h1);
    n(2);
    c(CmdRd, 2'h1);
    n(8);
    cb(4'h2);
    c(CmdPre, 2'h1);
    n(3);
  endtask : t_auto
  // An access to bank 2 cuts an auto precharge burst on bank 1, all four pairings.
  task automatic t_intr();
    for (int k = 0; k < 4; k++) begin
      c(CmdAct, 2'h1);
      c(CmdAct, 2'h2);
      n(2);
      c(k[1] ? CmdWr : CmdRd, 2'h1, 1'b1);
      c(k[0] ? CmdWr : CmdRd, 2'h2);
      n(1);
      cb(k[1] ? 4'h6 : 4'h4);
      chk(32'({readOutValid, writeStore}), 32'({k == 0, k[0]}));
      n(3);
      cb(4'h4);
      c(CmdPre, 2'h2);
      n(6);
    end
  endtask : t_intr
  // Continuous bursts, with and without single writes, never auto precharge.
  task automatic t_cont();
    rd(4'h0, 32'h0000000A);
    rd(4'hC, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, k ? 32'h0000003E : 32'h0000001E);
      rd(4'h0, k ? 32'h0000003E : 32'h0000001E);
      c(CmdAct, 2'h3);
      n(2);
      c(k ? CmdWr : CmdRd, 2'h3, 1'b1);
      n(10);
      cb(4'h8);
      chk(32'({burstActive, readOutValid, writeStore}), k ? 32'h5 : 32'h6);
      c(CmdTerm, 2'h3);
      n(1);
      chk(32'({burstActive, bankActive}), 32'h08);
      c(CmdPre, 2'h3);
      n(3);
    end
    // Single write mode with a fixed length: one element, then recovery and close.
    wr(4'h0, 32'h0000002A);
    c(CmdAct, 2'h3);
    n(2);
    c(CmdWr, 2'h3, 1'b1);
    n(2);
    cb(4'h8);
    n(1);
    cb(4'h0);
    wr(4'h0, 32'h0000000A);
  endtask : t_cont
  // Auto refresh ignores the address pins and steps the row counter.
  task automatic t_ref();
    logic [11:0] r;
    r = refreshRow;
    c(CmdRef, 2'h3, 1'b1);
    n(1);
    chk(32'({refreshPulse, refreshBusy}), 32'h3);
    n(9);
    chk(32'(refreshRow), 32'(r + 12'h001));
  endtask : t_ref
  // Self refresh ignores commands and refreshes on its own clock.
  task automatic t_self();
    logic [11:0] r;
    r = refreshRow;
    c(CmdRef, 2'h0, 1'b0, 1'b0);
    n(1, 1'b0);
    chk(32'(selfRefreshActive), 32'h1);
    c(CmdAct, 2'h0, 1'b0, 1'b0);
    n(800, 1'b0);
    cb(4'h0);
    chk(32'(refreshRow != r), 32'h1);
    n(3);
    chk(32'(selfRefreshActive), 32'h0);
  endtask : t_self
  // Active and precharge power-down, entered and left with idle commands.
  task automatic t_pd();
    c(CmdAct, 2'h2);
    n(2);
    n(2, 1'b0);
    chk(32'({powerDownActive, activePowerDown, inputBufferEnable}), 32'h6);
    c(CmdAct, 2'h0, 1'b0, 1'b0);
    n(1, 1'b0);
    cb(4'h4);
    n(3);
    chk(32'(powerDownActive), 32'h0);
    c(CmdPre, 2'h2);
    n(4);
    n(2, 1'b0);
    chk(32'({powerDownActive, activePowerDown}), 32'h2);
    n(3);
  endtask : t_pd
  // A clock enable low in mid-burst holds the burst and so delays its precharge.
  task automatic t_susp();
    c(CmdAct, 2'h0);
    n(2);
    c(CmdRd, 2'h0, 1'b1);
    n(1);
    n(2, 1'b0);
    chk(32'(clockSuspended), 32'h1);
    n(1);
    cb(4'h1);
    n(6);
    cb(4'h0);
  endtask : t_susp
  // Reset for four cycles, then every scenario in turn.
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    n(2);
    t_pre();
    t_auto();
    t_intr();
    t_cont();
    t_ref();
    t_self();
    t_ref();
    t_pd();
    t_susp();
    end_sim();
  end
endmodule : spr_ctl_tb_top
